// [design/pal_alarm_logic.sv]
// pressure supervision: filter, offset, auto-zero, alarm modes, delays, led
// assumes samples and key synchronous to clock; register port is one-cycle
`timescale 1ns/100ps

// Function
// - auto-zero starts after key held continuously over two seconds, or on the register request strobe
// - auto-zero zeroes reading when inside permitted range, else correction kept
// - option selects whether auto-zero clears user offset; default keeps it
// - after power-up led stays lit about three seconds
// - led lit normal, slow blink alarm, fast blink out of limits, dark error
// - after auto-zero: one long blink success, three short blinks refusal
// - unit change restores transmission limits and setpoints to operating limits
// - first-order low-pass filter smooths measured pressure, configurable constant
// - pressure, analog output and alarm each have forcing value and enable
// - disabled alarm mode never asserts alarm
// - sensor-fault mode alarm follows sensor error through the on and off delays
// - low mode: set below low setpoint, release above low plus hysteresis
// - high mode: set above high, release below low minus hysteresis
// - inside mode: set between setpoints, release outside by hysteresis
// - outside mode: set outside setpoints, release inside by hysteresis
// - power-up blocking suppresses alarm until a non-alarm condition seen
// - error-state setting drives alarm active or inactive on sensor failure
// - blocking, error state and hysteresis ignored in sensor-fault mode
// - alarm changes only after on or off delay elapses; both default zero
// - reset gives outside-band mode and setpoints at operating limits
module pal_alarm_logic #(
  parameter int TICK_CYC = pal_pkg::TICK_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        sensor_err,
  input  wire logic        key_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             alarm_out,
  output logic             led_out,
  output logic      [15:0] press_out,
  output logic      [15:0] aout_value
);

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [16:0] tick_cnt_q;
  logic        tick_q;
  wire         tick_end = (tick_cnt_q == 17'(TICK_CYC - 1));

  always_ff @(posedge clock) begin
    if (rst) begin
      tick_cnt_q <= 17'h0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_end ? 17'h0 : tick_cnt_q + 17'h1;
      tick_q     <= tick_end;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic        [15:0] ctrl_q, ton_q, toff_q, fp_q, fa_q;
  logic signed [15:0] sp_hi_q, sp_lo_q, hyst_q, ofs_q, tx_lo_q, tx_hi_q;
  logic        [2:0]  unit_q;
  logic        [3:0]  filt_k_q;
  logic               az_go, az_ok;

  wire pal_pkg::pal_mode_t mode = pal_pkg::pal_mode_t'(ctrl_q[2:0]);
  wire wr_ctrl  = reg_wr && (reg_addr == pal_pkg::REG_CTRL);
  wire wr_unit  = reg_wr && (reg_addr == pal_pkg::REG_UNIT);
  wire unit_chg = wr_unit && (reg_wdata[2:0] != unit_q);
  wire az_sw    = wr_ctrl && reg_wdata[pal_pkg::C_AZ_REQ];

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q   <= pal_pkg::CTRL_RST;
      unit_q   <= pal_pkg::UNIT_RST;
      sp_hi_q  <= pal_pkg::OP_MAX;
      sp_lo_q  <= pal_pkg::OP_MIN;
      tx_hi_q  <= pal_pkg::OP_MAX;
      tx_lo_q  <= pal_pkg::OP_MIN;
      hyst_q   <= 16'h0;
      ton_q    <= 16'h0;
      toff_q   <= 16'h0;
      ofs_q    <= 16'h0;
      filt_k_q <= 4'h0;
      fp_q     <= 16'h0;
      fa_q     <= 16'h0;
    end else begin
      // the request bit is a strobe, it is never stored
      if (wr_ctrl) ctrl_q <= reg_wdata & ~(16'h1 << pal_pkg::C_AZ_REQ);
      if (wr_unit) unit_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == pal_pkg::REG_HYST) hyst_q <= reg_wdata;
      if (reg_wr && reg_addr == pal_pkg::REG_TON) ton_q <= reg_wdata;
      if (reg_wr && reg_addr == pal_pkg::REG_TOFF) toff_q <= reg_wdata;
      if (reg_wr && reg_addr == pal_pkg::REG_FILT) filt_k_q <= reg_wdata[3:0];
      if (reg_wr && reg_addr == pal_pkg::REG_FP) fp_q <= reg_wdata;
      if (reg_wr && reg_addr == pal_pkg::REG_FA) fa_q <= reg_wdata;
      if (reg_wr && reg_addr == pal_pkg::REG_OFS) ofs_q <= reg_wdata;
      // offset cleared only when the option asks
      if (az_go && az_ok && ctrl_q[pal_pkg::C_AZCLR]) ofs_q <= 16'h0;
      // unit change wins over a limit write in the same cycle
      if (unit_chg) begin
        sp_hi_q <= pal_pkg::OP_MAX;
        sp_lo_q <= pal_pkg::OP_MIN;
        tx_hi_q <= pal_pkg::OP_MAX;
        tx_lo_q <= pal_pkg::OP_MIN;
      end else begin
        if (reg_wr && reg_addr == pal_pkg::REG_SPHI) sp_hi_q <= reg_wdata;
        if (reg_wr && reg_addr == pal_pkg::REG_SPLO) sp_lo_q <= reg_wdata;
        if (reg_wr && reg_addr == pal_pkg::REG_TXHI) tx_hi_q <= reg_wdata;
        if (reg_wr && reg_addr == pal_pkg::REG_TXLO) tx_lo_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // auto-zero key
  // ----------------------------------------------------------------
  logic [11:0] key_ms_q;
  wire         key_long = key_ms_q == 12'(pal_pkg::KEY_MS);

  // fires once per press, on the first tick past two seconds
  assign az_go = (tick_q && !key_n && key_long) || az_sw;

  always_ff @(posedge clock) begin
    if (rst || key_n) key_ms_q <= 12'h0;
    else if (tick_q && key_ms_q <= 12'(pal_pkg::KEY_MS)) key_ms_q <= key_ms_q + 12'h1;
  end

  // ----------------------------------------------------------------
  // measurement path
  // ----------------------------------------------------------------
  logic signed [15:0] raw_q, zero_q, filt_q, press_q;
  wire signed  [16:0] corr  = 17'(raw_q) - 17'(zero_q);
  wire signed  [16:0] fdiff = corr - 17'(filt_q);
  wire signed  [16:0] fstep = fdiff >>> filt_k_q;
  wire signed  [16:0] pcalc = 17'(filt_q) + 17'(ofs_q);
  // zeroing window on the uncorrected reading
  assign az_ok = (raw_q <= $signed(pal_pkg::AZ_RANGE)) && (raw_q >= -$signed(pal_pkg::AZ_RANGE));

  always_ff @(posedge clock) begin
    if (rst) begin
      raw_q   <= 16'h0;
      zero_q  <= 16'h0;
      filt_q  <= 16'h0;
      press_q <= 16'h0;
    end else begin
      if (sample_valid) raw_q <= sample_data;
      if (az_go && az_ok) begin
        // take the present reading as the new zero
        zero_q <= raw_q;
        filt_q <= 16'h0;
      end else if (sample_valid) begin
        // first-order low-pass, weight 2^-k per sample
        filt_q <= 16'(17'(filt_q) + fstep);
      end
      // offset added, then forcing replaces the measured value
      press_q <= ctrl_q[pal_pkg::C_FRC_P] ? fp_q : pcalc[15:0];
    end
  end

  // ----------------------------------------------------------------
  // alarm condition with hysteresis
  // ----------------------------------------------------------------
  wire signed [16:0] p     = 17'(press_q);
  wire signed [16:0] hi    = 17'(sp_hi_q);
  wire signed [16:0] lo    = 17'(sp_lo_q);
  wire signed [16:0] lo_ph = lo + 17'(hyst_q);
  wire signed [16:0] lo_mh = lo - 17'(hyst_q);
  wire signed [16:0] hi_ph = hi + 17'(hyst_q);
  wire signed [16:0] hi_mh = hi - 17'(hyst_q);
  logic cond_q, cond_d, blk_q, alarm_q;
  logic raw_vld_q, filt_vld_q, press_vld_q, cond_vld_q;
  logic [15:0] dly_q;

  always_comb begin
    cond_d = 1'b0;
    case (mode)
      pal_pkg::MODE_OFF:  cond_d = 1'b0;
      // sensor mode follows the error with no hysteresis
      pal_pkg::MODE_SENS: cond_d = sensor_err;
      pal_pkg::MODE_LOW:  cond_d = cond_q ? !(p > lo_ph) : (p < lo);
      // release against the lower setpoint, kept as specified
      pal_pkg::MODE_HIGH: cond_d = cond_q ? !(p < lo_mh) : (p > hi);
      pal_pkg::MODE_IN:   cond_d = cond_q ? !(p > hi_ph || p < lo_mh) : (p > lo && p < hi);
      pal_pkg::MODE_OUT:  cond_d = cond_q ? !(p < hi_mh && p > lo_ph) : (p > hi || p < lo);
      default:            cond_d = 1'b0;
    endcase
    // error state overrides evaluation in the threshold modes
    if (sensor_err && mode != pal_pkg::MODE_OFF && mode != pal_pkg::MODE_SENS)
      cond_d = ctrl_q[pal_pkg::C_ERRST];
  end

  // blocking not applied in sensor mode
  wire blk_on = ctrl_q[pal_pkg::C_PWRBLK] && blk_q && mode != pal_pkg::MODE_SENS;
  // the off mode never yields a target
  wire tgt    = cond_q && !blk_on && mode != pal_pkg::MODE_OFF;
  wire [15:0] dly_lim = tgt ? ton_q : toff_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      cond_q      <= 1'b0;
      blk_q       <= 1'b1;
      alarm_q     <= 1'b0;
      dly_q       <= 16'h0;
      raw_vld_q   <= 1'b0;
      filt_vld_q  <= 1'b0;
      press_vld_q <= 1'b0;
      cond_vld_q  <= 1'b0;
    end else begin
      cond_q <= cond_d;
      // the reset value of cond_q is no observation: wait until a real sample reaches it
      raw_vld_q   <= raw_vld_q || sample_valid;
      filt_vld_q  <= filt_vld_q || (sample_valid && raw_vld_q);
      press_vld_q <= filt_vld_q;
      cond_vld_q  <= press_vld_q;
      // released forever by the first evaluated non-alarm condition
      if (cond_vld_q && !cond_q) blk_q <= 1'b0;
      // qualify by delay, restart when the target reverts
      if (tgt == alarm_q) begin
        dly_q <= 16'h0;
      end else if (dly_q >= dly_lim) begin
        alarm_q <= tgt;
        dly_q   <= 16'h0;
      end else if (tick_q) begin
        dly_q <= dly_q + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // diagnostic led
  // ----------------------------------------------------------------
  pal_pkg::pal_led_t led_st_q;
  logic [11:0] led_tmr_q, seq_len_q, slow_tmr_q, fast_tmr_q;
  logic [2:0]  seq_n_q;
  logic        slow_q, fast_q, az_ok_q, az_fail_q;
  wire         out_lim  = p > 17'(tx_hi_q) || p < 17'(tx_lo_q);
  wire         slow_end = slow_tmr_q == 12'(pal_pkg::SLOW_MS - 1);
  wire         fast_end = fast_tmr_q == 12'(pal_pkg::FAST_MS - 1);
  wire         seq_end  = led_tmr_q == seq_len_q - 12'h1;
  // error dark before alarm blink before limit blink
  wire         run_led  = sensor_err ? 1'b0 : alarm_q ? slow_q : out_lim ? fast_q : 1'b1;
  // sequence starts with an off gap, lit on odd phases
  wire         led_d    = led_st_q == pal_pkg::LED_BOOT ? 1'b1 :
                          led_st_q == pal_pkg::LED_SEQ ? seq_n_q[0] : run_led;

  always_ff @(posedge clock) begin
    if (rst) begin
      slow_tmr_q <= 12'h0;
      fast_tmr_q <= 12'h0;
      slow_q     <= 1'b1;
      fast_q     <= 1'b1;
    end else if (tick_q) begin
      slow_tmr_q <= slow_end ? 12'h0 : slow_tmr_q + 12'h1;
      fast_tmr_q <= fast_end ? 12'h0 : fast_tmr_q + 12'h1;
      if (slow_end) slow_q <= !slow_q;
      if (fast_end) fast_q <= !fast_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      led_st_q  <= pal_pkg::LED_BOOT;
      led_tmr_q <= 12'h0;
      seq_n_q   <= 3'h0;
      seq_len_q <= 12'(pal_pkg::LONG_MS);
      az_ok_q   <= 1'b0;
      az_fail_q <= 1'b0;
    end else begin
      if (az_go) begin
        az_ok_q   <= az_ok;
        az_fail_q <= !az_ok;
      end
      case (led_st_q)
        pal_pkg::LED_BOOT: begin
          if (tick_q) led_tmr_q <= led_tmr_q + 12'h1;
          if (tick_q && led_tmr_q == 12'(pal_pkg::PWRUP_MS - 1)) begin
            led_st_q  <= pal_pkg::LED_RUN;
            led_tmr_q <= 12'h0;
          end
        end
        pal_pkg::LED_RUN, pal_pkg::LED_SEQ: begin
          if (az_go) begin
            // a new attempt restarts the report
            led_st_q  <= pal_pkg::LED_SEQ;
            led_tmr_q <= 12'h0;
            seq_n_q   <= az_ok ? 3'h2 : 3'h6;
            seq_len_q <= az_ok ? 12'(pal_pkg::LONG_MS) : 12'(pal_pkg::SHORT_MS);
          end else if (led_st_q == pal_pkg::LED_SEQ && tick_q) begin
            led_tmr_q <= seq_end ? 12'h0 : led_tmr_q + 12'h1;
            if (seq_end) seq_n_q <= seq_n_q - 3'h1;
            if (seq_end && seq_n_q == 3'h1) led_st_q <= pal_pkg::LED_RUN;
          end
        end
        default: led_st_q <= pal_pkg::LED_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs and register read
  // ----------------------------------------------------------------
  logic [15:0] rd_tab [16];
  assign rd_tab[pal_pkg::REG_CTRL]  = ctrl_q;
  assign rd_tab[pal_pkg::REG_UNIT]  = {13'h0, unit_q};
  assign rd_tab[pal_pkg::REG_SPHI]  = sp_hi_q;
  assign rd_tab[pal_pkg::REG_SPLO]  = sp_lo_q;
  assign rd_tab[pal_pkg::REG_HYST]  = hyst_q;
  assign rd_tab[pal_pkg::REG_TON]   = ton_q;
  assign rd_tab[pal_pkg::REG_TOFF]  = toff_q;
  assign rd_tab[pal_pkg::REG_OFS]   = ofs_q;
  assign rd_tab[pal_pkg::REG_FILT]  = {12'h0, filt_k_q};
  assign rd_tab[pal_pkg::REG_FP]    = fp_q;
  assign rd_tab[pal_pkg::REG_FA]    = fa_q;
  assign rd_tab[pal_pkg::REG_TXLO]  = tx_lo_q;
  assign rd_tab[pal_pkg::REG_TXHI]  = tx_hi_q;
  assign rd_tab[pal_pkg::REG_STAT]  = {9'h0, az_fail_q, az_ok_q, blk_on, cond_q, alarm_q, out_lim, sensor_err};
  assign rd_tab[pal_pkg::REG_PRESS] = press_q;
  assign rd_tab[pal_pkg::REG_ZERO]  = zero_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata  <= 16'h0;
      alarm_out  <= 1'b0;
      led_out    <= 1'b1;
      press_out  <= 16'h0;
      aout_value <= 16'h0;
    end else begin
      // read data valid only the cycle after the strobe
      reg_rdata  <= reg_rd ? rd_tab[reg_addr] : 16'h0;
      alarm_out  <= ctrl_q[pal_pkg::C_FRC_AL] ? ctrl_q[pal_pkg::C_FRC_ALV] : alarm_q;
      aout_value <= ctrl_q[pal_pkg::C_FRC_A] ? fa_q : press_q;
      press_out  <= press_q;
      led_out    <= led_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  key_start_a: assert property ($rose(key_long) |-> $past(key_ms_q) == 12'(pal_pkg::KEY_MS - 1))
    else $error("key count jumped to the long-press value");
  az_zero_a: assert property (az_go && az_ok |=> zero_q == $past(raw_q) && filt_q == 16'h0)
    else $error("auto-zero did not zero the reading");
  az_keep_a: assert property (az_go && !az_ok && !sample_valid |=> $stable(zero_q))
    else $error("refused auto-zero changed correction");
  boot_led_a: assert property (led_st_q == pal_pkg::LED_BOOT |=> led_out)
    else $error("led dark during power-up");
  err_led_a: assert property (led_st_q == pal_pkg::LED_RUN && sensor_err |=> !led_out)
    else $error("led lit on device error");
  unit_dflt_a: assert property (unit_chg |=> sp_hi_q == pal_pkg::OP_MAX && tx_lo_q == pal_pkg::OP_MIN)
    else $error("unit change kept old limits");
  off_mode_a: assert property (mode == pal_pkg::MODE_OFF |-> !tgt)
    else $error("alarm target in off mode");
  sens_mode_a: assert property (mode == pal_pkg::MODE_SENS [*2] |-> cond_q == $past(sensor_err))
    else $error("sensor mode does not track error");
  low_set_a: assert property (mode == pal_pkg::MODE_LOW && !sensor_err && p < lo |=> cond_q)
    else $error("low alarm not set");
  out_hold_a: assert property (mode == pal_pkg::MODE_OUT && !sensor_err && cond_q && p >= hi_mh |=> cond_q)
    else $error("outside alarm left inside hysteresis");
  blk_hold_a: assert property (blk_on |-> !tgt)
    else $error("alarm target while blocked");
  err_state_a: assert property (sensor_err && mode == pal_pkg::MODE_LOW |=> cond_q == $past(ctrl_q[pal_pkg::C_ERRST]))
    else $error("error state not applied");
  dly_rise_a: assert property ($rose(alarm_q) |-> $past(tgt) && $past(dly_q) >= $past(ton_q))
    else $error("alarm rose before on-delay");
  frc_al_a: assert property (ctrl_q[pal_pkg::C_FRC_AL] |=> alarm_out == $past(ctrl_q[pal_pkg::C_FRC_ALV]))
    else $error("forced alarm value not driven");

  cov_low_c:  cover property (mode == pal_pkg::MODE_LOW ##1 $rose(alarm_q));
  cov_azok_c: cover property (az_go && az_ok);
  cov_azno_c: cover property (az_go && !az_ok);
  cov_unit_c: cover property (unit_chg);

endmodule

// [design/pal_pkg.sv]
// constants, types and register map of the pressure alarm logic
// assumes a 100 MHz system clock and a 1 ms internal time base
package pal_pkg;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 100;
  localparam int TICK_US   = 1000;
  localparam int TICK_CYC  = TICK_US * CLK_MHZ;
  // times below are counted in 1 ms ticks
  localparam int KEY_MS    = 2000;
  localparam int PWRUP_MS  = 3000;
  localparam int SLOW_MS   = 500;
  localparam int FAST_MS   = 100;
  localparam int LONG_MS   = 1000;
  localparam int SHORT_MS  = 150;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF  = 3'h0,
    MODE_SENS = 3'h1,
    MODE_LOW  = 3'h2,
    MODE_HIGH = 3'h3,
    MODE_IN   = 3'h4,
    MODE_OUT  = 3'h5
  } pal_mode_t;

  typedef enum logic [1:0] {
    LED_BOOT = 2'h0,
    LED_RUN  = 2'h1,
    LED_SEQ  = 2'h2
  } pal_led_t;

  // ----------------------------------------------------------------
  // register indices and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_UNIT  = 4'h1;
  localparam logic [3:0] REG_SPHI  = 4'h2;
  localparam logic [3:0] REG_SPLO  = 4'h3;
  localparam logic [3:0] REG_HYST  = 4'h4;
  localparam logic [3:0] REG_TON   = 4'h5;
  localparam logic [3:0] REG_TOFF  = 4'h6;
  localparam logic [3:0] REG_OFS   = 4'h7;
  localparam logic [3:0] REG_FILT  = 4'h8;
  localparam logic [3:0] REG_FP    = 4'h9;
  localparam logic [3:0] REG_FA    = 4'ha;
  localparam logic [3:0] REG_TXLO  = 4'hb;
  localparam logic [3:0] REG_TXHI  = 4'hc;
  localparam logic [3:0] REG_STAT  = 4'hd;
  localparam logic [3:0] REG_PRESS = 4'he;
  localparam logic [3:0] REG_ZERO  = 4'hf;

  localparam int C_PWRBLK  = 3;
  localparam int C_ERRST   = 4;
  localparam int C_AZCLR   = 5;
  localparam int C_FRC_P   = 6;
  localparam int C_FRC_A   = 7;
  localparam int C_FRC_AL  = 8;
  localparam int C_FRC_ALV = 9;
  localparam int C_AZ_REQ  = 10;

  localparam logic [15:0] CTRL_RST = 16'h0005;
  localparam logic [15:0] OP_MAX   = 16'h7d00;
  localparam logic [15:0] OP_MIN   = 16'h8300;
  localparam logic [15:0] AZ_RANGE = 16'h0320;
  localparam logic [2:0]  UNIT_RST = 3'h0;

endpackage

// [bench/pal_sensor_model.sv]
// sensor measurement path model: periodic raw samples and an error level
// assumes the bench sets level and fault; single clock, synchronous reset
`timescale 1ns/100ps
module pal_sensor_model #(
  parameter int PERIOD = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] level,
  input  wire logic        fault,
  output logic             sample_valid,
  output logic      [15:0] sample_data,
  output logic             sensor_err
);
  int  cnt_q;
  wire fire = !rst && cnt_q == PERIOD - 1;

  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  // data between samples is inverted so nothing can lean on a held value
  always_ff @(posedge clock) begin
    cnt_q        <= (rst || fire) ? 0 : cnt_q + 1;
    sample_valid <= fire;
    sample_data  <= fire ? level : ~level;
    sensor_err   <= fault;
  end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the pressure alarm logic
// assumes the sensor model on the sample side and the one-cycle register port
`timescale 1ns/100ps
module tb_top;
  localparam int TC = 10;
  logic        clock, rst, key_n, reg_wr, reg_rd, fault, alarm_out, led_out;
  logic        sample_valid, sensor_err;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, level, press_out, aout_value, sample_data;
  int          miscompares, n_checks;

  pal_sensor_model sensor (.clock(clock), .rst(rst), .level(level), .fault(fault),
    .sample_valid(sample_valid), .sample_data(sample_data), .sensor_err(sensor_err));
  pal_alarm_logic #(.TICK_CYC(TC)) dut (.clock(clock), .rst(rst), .sample_valid(sample_valid),
    .sample_data(sample_data), .sensor_err(sensor_err), .key_n(key_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alarm_out(alarm_out), .led_out(led_out), .press_out(press_out), .aout_value(aout_value));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input string what, input logic [3:0] a, input logic [15:0] exp,
                    input logic [15:0] m = 16'hffff);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    cmp16(what, exp, reg_rdata & m);
  endtask
  task automatic wait_ticks(input int n);
    repeat (n * TC) @(posedge clock);
    #1;
  endtask
  // long enough for two samples plus the six-edge path to alarm_out
  task automatic settle;
    repeat (16) @(posedge clock);
    #1;
  endtask
  task automatic set_press(input logic [15:0] v);
    @(posedge clock);
    level <= v;
    settle();
  endtask
  task automatic set_fault(input logic v);
    @(posedge clock);
    fault <= v;
    settle();
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // tests need about 50000 cycles
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; key_n = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; fault = 1'b0;
    reg_addr = 4'h0; reg_wdata = 16'h0000; level = 16'h0064;
    miscompares = 0; n_checks = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd("ctrl", pal_pkg::REG_CTRL, pal_pkg::CTRL_RST);
    rd("sp_hi", pal_pkg::REG_SPHI, pal_pkg::OP_MAX);
    rd("sp_lo", pal_pkg::REG_SPLO, pal_pkg::OP_MIN);
    rd("ton", pal_pkg::REG_TON, 16'h0000);
    cmp1("boot led", 1'b1, led_out);
    wr(pal_pkg::REG_OFS, 16'h000a);
    set_press(16'h0064);
    rd("press", pal_pkg::REG_PRESS, 16'h006e);
    cmp16("press out", 16'h006e, press_out);
    cmp16("aout", 16'h006e, aout_value);
    $display("test reset and offset done");
    wr(pal_pkg::REG_SPHI, 16'h03e8);
    wr(pal_pkg::REG_HYST, 16'h0064);
    wr(pal_pkg::REG_TON, 16'h0005);
    set_press(16'h04b0);
    cmp1("on delay", 1'b0, alarm_out);
    wait_ticks(8);
    cmp1("outside set", 1'b1, alarm_out);
    wr(pal_pkg::REG_TON, 16'h0000);
    set_press(16'h03b6);
    cmp1("outside hyst", 1'b1, alarm_out);
    set_press(16'h0352);
    cmp1("outside clear", 1'b0, alarm_out);
    $display("test outside band done");
    wr(pal_pkg::REG_SPLO, 16'h0000);
    wr(pal_pkg::REG_CTRL, 16'h0002);
    set_press(16'hffe2);
    cmp1("low set", 1'b1, alarm_out);
    set_press(16'h0032);
    cmp1("low hyst", 1'b1, alarm_out);
    set_press(16'h0096);
    cmp1("low clear", 1'b0, alarm_out);
    wr(pal_pkg::REG_CTRL, 16'h0003);
    set_press(16'h044c);
    cmp1("high set", 1'b1, alarm_out);
    set_press(16'h0032);
    cmp1("high hold", 1'b1, alarm_out);
    set_press(16'hff6a);
    cmp1("high clear", 1'b0, alarm_out);
    wr(pal_pkg::REG_CTRL, 16'h0004);
    set_press(16'h01f4);
    cmp1("inside set", 1'b1, alarm_out);
    set_press(16'h0410);
    cmp1("inside hold", 1'b1, alarm_out);
    set_press(16'h04b0);
    cmp1("inside clear", 1'b0, alarm_out);
    wr(pal_pkg::REG_CTRL, 16'h0012);
    set_fault(1'b1);
    cmp1("error state", 1'b1, alarm_out);
    wr(pal_pkg::REG_CTRL, 16'h0011);
    set_fault(1'b0);
    cmp1("sensor idle", 1'b0, alarm_out);
    set_fault(1'b1);
    cmp1("sensor fault", 1'b1, alarm_out);
    set_fault(1'b0);
    wr(pal_pkg::REG_CTRL, 16'h0000);
    set_press(16'hffe2);
    cmp1("mode off", 1'b0, alarm_out);
    wr(pal_pkg::REG_CTRL, 16'h0300);
    settle();
    cmp1("forced alarm", 1'b1, alarm_out);
    wr(pal_pkg::REG_FA, 16'h1234);
    wr(pal_pkg::REG_FP, 16'h0abc);
    wr(pal_pkg::REG_CTRL, 16'h03c0);
    settle();
    cmp16("forced press", 16'h0abc, press_out);
    cmp16("forced aout", 16'h1234, aout_value);
    $display("test alarm modes done");
    wr(pal_pkg::REG_UNIT, 16'h0001);
    rd("unit sp_hi", pal_pkg::REG_SPHI, pal_pkg::OP_MAX);
    rd("unit sp_lo", pal_pkg::REG_SPLO, pal_pkg::OP_MIN);
    set_press(16'h0096);
    wr(pal_pkg::REG_CTRL, 16'h0400);
    rd("zero", pal_pkg::REG_ZERO, 16'h0096);
    settle();
    rd("press zeroed", pal_pkg::REG_PRESS, 16'h000a);
    rd("az ok", pal_pkg::REG_STAT, 16'h0020, 16'h0060);
    $display("test unit and register zero done");
    wr(pal_pkg::REG_FILT, 16'h0001);
    set_press(16'h03e8);
    @(posedge clock);
    key_n <= 1'b0;
    wait_ticks(1900);
    @(posedge clock);
    key_n <= 1'b1;
    rd("short press", pal_pkg::REG_STAT, 16'h0020, 16'h0060);
    @(posedge clock);
    key_n <= 1'b0;
    wait_ticks(2050);
    cmp1("short blink off", 1'b0, led_out);
    @(posedge clock);
    key_n <= 1'b1;
    rd("zero kept", pal_pkg::REG_ZERO, 16'h0096);
    rd("az refused", pal_pkg::REG_STAT, 16'h0040, 16'h0060);
    wait_ticks(150);
    cmp1("short blink on", 1'b1, led_out);
    wait_ticks(800);
    cmp1("led normal", 1'b1, led_out);
    // halving steps stall one count short of the 850 target
    cmp16("filtered", 16'h035b, press_out);
    set_fault(1'b1);
    cmp1("led error", 1'b0, led_out);
    set_fault(1'b0);
    set_press(16'h7e00);
    @(posedge clock);
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    wr(pal_pkg::REG_CTRL, 16'h000d);
    settle();
    cmp1("blocked", 1'b0, alarm_out);
    rd("block flag", pal_pkg::REG_STAT, 16'h0018, 16'h0018);
    set_press(16'h0000);
    set_press(16'h7e00);
    cmp1("unblocked", 1'b1, alarm_out);
    $display("test power-up blocking done");
    $display("test key and led done");
    print_verdict();
  end
endmodule
